// >>> dv/ltg_dev_model.sv
/*
 * device-side model: stamps each granted activate, precharge and read and counts spacing
 * violations; keeps a mode register image.
 * assumes the guard outputs are registered on the shared clock.
 */
`timescale 1ns/1ps
`include "ltg_cfg.svh"
module ltg_dev_model #(
    parameter logic [7:0] MR_DEFAULT = 8'h00 // arbitrary image
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_grant,
    input wire ltg_pkg::ltg_cmd_t i_cmd,
    input wire logic [1:0] i_bank,
    input wire logic i_cke,
    input wire logic i_wr_last,
    output logic [15:0] o_viol
);
    // ps minimum rounded up to clocks, raised to the clock floor
    function automatic int cc(int ps, int n);
        int c;
        c = (ps + `LTG_CLK_PS - 1) / `LTG_CLK_PS;
        return (c > n) ? c : n;
    endfunction
    localparam int RP = cc(`LTG_RP_PS, `LTG_RP_NCK);
    localparam int RAS = cc(`LTG_RAS_PS, `LTG_RAS_NCK);
    localparam int RTP = cc(`LTG_RTP_PS, `LTG_RTP_NCK);
    localparam int WTR = cc(`LTG_WTR_PS, `LTG_WTR_NCK);
    localparam int RRD = cc(`LTG_RRD_PS, `LTG_RRD_NCK);
    localparam int FAW = cc(`LTG_FAW_PS, `LTG_FAW_NCK);
    localparam int XP = cc(`LTG_XP_PS, `LTG_XP_NCK);
    int cyc, v, t_any, t_prea, t_rise, t_wrl;
    int t_act[4], t_pre[4], t_rd[4], hist[4];
    logic cke_q;
    logic [7:0] mr_q;
    // true when at least n clocks have passed since t
    function automatic logic ok(int t, int n);
        return (cyc - t) >= n;
    endfunction
    // stamp commands and count spacing violations
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cyc = 0;
            t_any = -99;
            t_prea = -99;
            t_rise = -99;
            t_wrl = -99;
            for (int i = 0; i < 4; i++) begin
                t_act[i] = -99;
                t_pre[i] = -99;
                t_rd[i] = -99;
                hist[i] = -99;
            end
            cke_q <= 1'b1;
            mr_q <= MR_DEFAULT;
            o_viol <= 16'h0000;
        end else begin
            cyc = cyc + 1;
            v = 0;
            if (i_wr_last) t_wrl = cyc + 1; // grants are seen a clock late
            if (i_cke && !cke_q) t_rise = cyc;
            cke_q <= i_cke;
            if (i_grant) begin
                v += !i_cke + !ok(t_rise, XP);
                case (i_cmd)
                ltg_pkg::LTG_CMD_ACT: begin
                    v += !ok(t_any, RRD) + !ok(hist[0], FAW);
                    v += !ok(t_pre[i_bank], RP);
                    v += !ok(t_prea, RP);
                    v += !ok(t_act[i_bank], RAS + RP);
                    hist = '{hist[1], hist[2], hist[3], cyc};
                    t_act[i_bank] = cyc;
                    t_any = cyc;
                end
                ltg_pkg::LTG_CMD_PRE: begin
                    v += !ok(t_rd[i_bank], RTP);
                    v += !ok(t_act[i_bank], RAS);
                    t_pre[i_bank] = cyc;
                end
                ltg_pkg::LTG_CMD_PREA: begin
                    for (int i = 0; i < 4; i++) begin
                        v += !ok(t_rd[i], RTP) + !ok(t_act[i], RAS);
                    end
                    t_prea = cyc;
                end
                ltg_pkg::LTG_CMD_RD: begin
                    v += !ok(t_wrl, WTR);
                    t_rd[i_bank] = cyc;
                end
                ltg_pkg::LTG_CMD_OTHER: mr_q <= MR_DEFAULT;
                default: ;
                endcase
            end
            o_viol <= o_viol + v[15:0];
        end
    end
endmodule // ltg_dev_model

// >>> dv/test_lpddr2_command_timing_guard.sv
/*
 * self-checking bench of the command spacing guard: directed pairs,
 * power exits, row age flag and seeded random traffic.
 * assumes a 40 ns clock and the device model beside the guard.
 */
`timescale 1ns/1ps
`include "ltg_cfg.svh"
module test_lpddr2_command_timing_guard;
    localparam int DPD = 20;
    localparam int RMAX = 40;
    localparam ltg_pkg::ltg_cmd_t c_act = ltg_pkg::LTG_CMD_ACT;
    localparam ltg_pkg::ltg_cmd_t c_rd = ltg_pkg::LTG_CMD_RD;
    localparam ltg_pkg::ltg_cmd_t c_wr = ltg_pkg::LTG_CMD_WR;
    localparam ltg_pkg::ltg_cmd_t c_pre = ltg_pkg::LTG_CMD_PRE;
    localparam ltg_pkg::ltg_cmd_t c_pra = ltg_pkg::LTG_CMD_PREA;
    localparam ltg_pkg::ltg_cmd_t c_oth = ltg_pkg::LTG_CMD_OTHER;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_req = 1'b0;
    ltg_pkg::ltg_cmd_t i_cmd = ltg_pkg::LTG_CMD_NOP;
    logic [1:0] i_bank = 2'h0;
    logic i_wr_last = 1'b0;
    logic [1:0] i_pw_req = 2'h0;
    logic i_derate = 1'b0;
    logic i_configured = 1'b1;
    logic i_slow_faw = 1'b0;
    logic o_grant, o_cke;
    ltg_pkg::ltg_cmd_t o_cmd;
    logic [1:0] o_bank;
    logic [3:0] o_expire, open_b;
    logic [15:0] viol;
    logic [31:0] lfsr = 32'h0001509A;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    int t, t0, tw;
    // 25 MHz clock and a cycle count for spacing figures
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    ltg_guard #(.DPD_CYC(DPD), .RASMAX_CYC(RMAX)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_cmd(i_cmd),
        .i_bank(i_bank), .i_wr_last(i_wr_last), .i_pw_req(i_pw_req),
        .i_derate(i_derate), .i_configured(i_configured),
        .i_slow_faw(i_slow_faw), .o_grant(o_grant), .o_cmd(o_cmd),
        .o_bank(o_bank), .o_cke(o_cke), .o_expire(o_expire));
    ltg_dev_model u_dev (
        .i_clk(i_clk), .i_rst(i_rst), .i_grant(o_grant), .i_cmd(o_cmd),
        .i_bank(o_bank), .i_cke(o_cke), .i_wr_last(i_wr_last),
        .o_viol(viol));
    function automatic logic [31:0] nxt(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // expected spacing: derate, boot floor, round up, clock floor
    function automatic int gap(int ps, int nck, logic drt, logic boot);
        int c;
        if (drt) ps = ps + `LTG_DERATE_PS;
        if (boot && ps < `LTG_BOOT_PS) ps = `LTG_BOOT_PS;
        c = (ps + `LTG_CLK_PS - 1) / `LTG_CLK_PS;
        if (`LTG_CLK_PS > `LTG_FLOOR_PS && c < nck) c = nck;
        return c;
    endfunction
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    task automatic chk(string n, logic ok);
        check(n, {31'h0, ok}, 32'h1);
    endtask
    task automatic print_verdict;
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // request one command and hold it until the grant is seen
    task automatic issue(ltg_pkg::ltg_cmd_t c, logic [1:0] b, logic wl);
        int n;
        @(posedge i_clk);
        i_req <= 1'b1;
        i_cmd <= c;
        i_bank <= b;
        i_wr_last <= wl;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            if (n == 0) tw = cyc;
            i_wr_last <= 1'b0;
            n++;
        end while (o_grant !== 1'b1 && n < 200);
        chk("grant", o_grant === 1'b1);
        check("cmd", {29'h0, o_cmd}, {29'h0, c});
        check("bank", {30'h0, o_bank}, {30'h0, b});
        t = cyc;
        if (c == c_act) open_b[b] = 1'b1;
        if (c == c_pre) open_b[b] = 1'b0;
        if (c == c_pra) open_b = 4'h0;
    endtask
    task automatic idle(int n);
        @(posedge i_clk);
        i_req <= 1'b0;
        repeat (n) @(posedge i_clk);
        #1;
        check("idle cmd", {29'h0, o_cmd}, 32'h0);
    endtask
    task automatic pair(ltg_pkg::ltg_cmd_t c1, logic [1:0] b1,
        ltg_pkg::ltg_cmd_t c2, logic [1:0] b2, int e);
        issue(c1, b1, 1'b0);
        t0 = t;
        issue(c2, b2, 1'b0);
        chk("gap min", t - t0 >= e);
        chk("gap max", t - t0 <= e + 1);
        idle(12);
    endtask
    task automatic wait_cke(logic lvl, int lim);
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_cke !== lvl && n < lim);
        chk("cke level", o_cke === lvl);
    endtask
    // enter a power state, leave at once, then time the first grant
    task automatic pw(logic [1:0] m, int lo, int ex);
        idle(3);
        i_pw_req <= m;
        wait_cke(1'b0, 10);
        t0 = cyc;
        @(posedge i_clk);
        i_pw_req <= 2'h0;
        wait_cke(1'b1, DPD + 50);
        chk("cke low min", cyc - t0 >= lo);
        chk("cke low max", cyc - t0 <= lo + 2);
        t0 = cyc;
        issue(c_oth, 2'h0, 1'b0);
        chk("exit min", t - t0 >= ex);
        chk("exit max", t - t0 <= ex + 2);
    endtask
    // main sequence
    initial begin
        ltg_pkg::ltg_cmd_t c;
        logic [1:0] b;
        int e, xs;
        open_b = 4'h0;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        idle(2);
        for (int p = 0; p < 2; p++) begin
            i_derate <= p[0];
            i_configured <= !p[0];
            e = gap(`LTG_RP_PS, `LTG_RP_NCK, p[0], !p[0]);
            pair(c_pra, 2'h0, c_act, 2'h0, e);
            pair(c_pre, 2'h1, c_act, 2'h1, e);
            e = gap(`LTG_RRD_PS, `LTG_RRD_NCK, p[0], !p[0]);
            pair(c_act, 2'h2, c_act, 2'h3, e);
            e = gap(`LTG_RTP_PS, `LTG_RTP_NCK, 1'b0, !p[0]);
            pair(c_rd, 2'h0, c_pre, 2'h0, e);
            e = gap(`LTG_RAS_PS, `LTG_RAS_NCK, p[0], !p[0]);
            pair(c_act, 2'h0, c_pre, 2'h0, e);
        end
        i_derate <= 1'b0;
        i_configured <= 1'b1;
        e = gap(`LTG_WTR_PS, `LTG_WTR_NCK, 1'b0, 1'b0);
        issue(c_wr, 2'h2, 1'b0);
        issue(c_rd, 2'h2, 1'b1);
        chk("write to read", t - tw >= e && t - tw <= e + 1);
        issue(c_pra, 2'h0, 1'b0);
        e = gap(`LTG_CKESR_PS, `LTG_CKESR_NCK, 1'b0, 1'b0);
        xs = gap(`LTG_RFCAB_PS + `LTG_XSR_EXTRA_PS, `LTG_XSR_NCK, 0, 0);
        pw(2'h1, e, xs);
        pw(2'h2, 2, gap(`LTG_XP_PS, `LTG_XP_NCK, 1'b0, 1'b0));
        pw(2'h3, DPD, xs);
        issue(c_act, 2'h0, 1'b0);
        t0 = t;
        idle(RMAX - 8);
        chk("no early expire", o_expire[0] === 1'b0);
        while (o_expire[0] !== 1'b1 && cyc - t0 < RMAX + 9) begin
            @(posedge i_clk);
            #1;
        end
        chk("expire min", cyc - t0 >= RMAX - 4);
        chk("expire max", cyc - t0 <= RMAX + 1);
        issue(c_pre, 2'h0, 1'b0);
        idle(3);
        check("expire clear", {28'h0, o_expire}, 32'h0);
        for (int i = 0; i < 150; i++) begin
            lfsr = nxt(lfsr);
            b = lfsr[1:0];
            case (lfsr[4:2])
            3'h0, 3'h1: c = c_act;
            3'h2: c = c_rd;
            3'h3: c = c_wr;
            3'h6: c = c_pra;
            3'h7: c = c_oth;
            default: c = c_pre;
            endcase
            if (c == c_act && open_b[b]) c = c_pre;
            if ((c == c_rd || c == c_wr) && !open_b[b]) c = c_act;
            if (lfsr[7:5] == 3'h0) begin
                idle(int'(lfsr[12:11]));
                i_derate <= lfsr[8];
                i_configured <= lfsr[9];
                i_slow_faw <= lfsr[10];
            end
            issue(c, b, lfsr[13]);
        end
        idle(5);
        check("violations", {16'h0, viol}, 32'h0);
        print_verdict();
    end
    // watchdog: 20000 clocks, far beyond the expected run
    initial begin
        #800000;
        err_count++;
        print_verdict();
    end
endmodule // test_lpddr2_command_timing_guard

// >>> logic/ltg_bank.sv
/*
 * per-bank timers: precharge, row cycle, row active, read to precharge,
 * open row age.  assumes requests are already accepted by the top.
 */
`timescale 1ns/1ps
`include "ltg_cfg.svh"
module ltg_bank (
    input wire logic i_clk,
    input wire logic i_rst,
    ltg_bank_if.bnk b,
    input wire logic [15:0] i_rtp_cyc,
    input wire logic i_pre_all
);
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bank
            logic [15:0] pre_q, pre_d, act_q, act_d, rtp_q, rtp_d;
            logic [23:0] age_q, age_d;
            logic open_q, open_d;
            logic hit;
            // next state of one bank's timers
            always_comb begin
                hit = (b.bank == 2'(g));
                pre_d = (pre_q != 16'h0) ? pre_q - 16'h1 : pre_q;
                act_d = (act_q != 16'h0) ? act_q - 16'h1 : act_q;
                rtp_d = (rtp_q != 16'h0) ? rtp_q - 16'h1 : rtp_q;
                age_d = open_q ? age_q + 24'h1 : 24'h0;
                open_d = open_q;
                if (b.act && hit) begin
                    act_d = b.rc_cyc;
                    pre_d = b.ras_cyc;
                    open_d = 1'b1;
                    age_d = 24'h0;
                end
                if (b.rd && hit)
                    rtp_d = i_rtp_cyc;
                if (b.pre && (hit || i_pre_all)) begin
                    pre_d = b.rp_cyc;
                    open_d = 1'b0;
                end
            end
            // registers of one bank
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    pre_q <= 16'h0;
                    act_q <= 16'h0;
                    rtp_q <= 16'h0;
                    age_q <= 24'h0;
                    open_q <= 1'b0;
                end else begin
                    pre_q <= pre_d;
                    act_q <= act_d;
                    rtp_q <= rtp_d;
                    age_q <= age_d;
                    open_q <= open_d;
                end
            end
            // act needs both the precharge and the row cycle timers spent
            assign b.act_ok[g] = !open_q && pre_q == 16'h0 && act_q == 16'h0;
            assign b.pre_ok[g] = pre_q == 16'h0 && rtp_q == 16'h0;
            assign b.expire[g] = open_q && age_q >= b.rasmax_cyc;
            assign b.open[g] = open_q;
        end
    endgenerate
endmodule // ltg_bank

// >>> logic/ltg_bank_if.sv
/*
 * interface between the guard top and the per-bank timer.
 * assumes a single clock shared by both ends.
 */
`timescale 1ns/1ps
interface ltg_bank_if;
    logic act;
    logic pre;
    logic rd;
    logic wr_end;
    logic [15:0] rp_cyc;
    logic [15:0] rc_cyc;
    logic [15:0] ras_cyc;
    logic [23:0] rasmax_cyc;
    logic [3:0] act_ok;
    logic [3:0] pre_ok;
    logic [3:0] expire;
    logic [3:0] open;
    logic [1:0] bank;
    modport top (output act, pre, rd, wr_end, rp_cyc, rc_cyc, ras_cyc,
        rasmax_cyc, bank, input act_ok, pre_ok, expire, open);
    modport bnk (input act, pre, rd, wr_end, rp_cyc, rc_cyc, ras_cyc,
        rasmax_cyc, bank, output act_ok, pre_ok, expire, open);
endinterface

// >>> logic/ltg_cfg.svh
/*
 * timing constants of the command spacing guard for a low-power ddr
 * sdram core; assumes a 25 MHz controller clock (40 ns period).
 */
`ifndef LTG_CFG_SVH
`define LTG_CFG_SVH
`define LTG_CLK_PS 40000
// minimum times in ps, as printed in ns; last two in us, ras max a maximum
`define LTG_CKESR_PS 15000
`define LTG_XSR_EXTRA_PS 10000
`define LTG_RFCAB_PS 130000
`define LTG_XP_PS 7500
`define LTG_RTP_PS 7500
`define LTG_RP_PS 15000
`define LTG_RCD_PS 15000
`define LTG_RAS_PS 42000
`define LTG_WTR_PS 7500
`define LTG_RRD_PS 10000
`define LTG_FAW_PS 50000
`define LTG_FAW_SLOW_PS 60000
`define LTG_DERATE_PS 1875
`define LTG_DPD_US 500
`define LTG_RAS_MAX_US 70
// clock-count floors
`define LTG_CKESR_NCK 3
`define LTG_XSR_NCK 2
`define LTG_XP_NCK 2
`define LTG_RTP_NCK 2
`define LTG_RP_NCK 3
`define LTG_RAS_NCK 3
`define LTG_WTR_NCK 2
`define LTG_RRD_NCK 2
`define LTG_FAW_NCK 8
// boot timing set in ps
`define LTG_BOOT_PS 18000
// clock period above which the clock-count floors apply, ps
`define LTG_FLOOR_PS 6000
`define LTG_CNT_W 16
`define LTG_LONG_W 24
`endif

// >>> logic/ltg_guard.sv
/*
 * command spacing guard: sits in the memory controller in front of a
 * low-power ddr sdram, holding each requested command until its minimum
 * spacing is met, and driving the clock enable for the power states.
 * assumes one request held stable until o_grant, inputs synchronous.
 */
// Function
// - keep clock enable low in self-refresh for max of 3 clocks, 15 ns
// - after self-refresh exit wait refresh cycle plus 10 ns, 2 clocks
// - after power-down exit wait max of 7.5 ns and 2 clocks
// - read to precharge same bank spaced max of 7.5 ns, 2 clocks
// - single-bank precharge to activate waits max of 15 ns, 3 clocks
// - all-bank precharge to activate waits max of 15 ns, 3 clocks
// - last write data to read waits max of 7.5 ns, 2 clocks
// - activates to different banks spaced max of 10 ns, 2 clocks
// - at most four activates in rolling window, 50 or 60 ns, 8 clocks
// - stay in deep power-down at least 500 us before exit
// - same-bank activates spaced by row active plus precharge time
// - derating adds 1.875 ns to row timings when in force
// - use boot timing set until the device is configured
// - clock-count floors apply only when period exceeds 6 ns
`timescale 1ns/1ps
`include "ltg_cfg.svh"
module ltg_guard #(
    parameter int DPD_CYC = `LTG_DPD_US * 1000000 / `LTG_CLK_PS,
    parameter int RASMAX_CYC = `LTG_RAS_MAX_US * 1000000 / `LTG_CLK_PS
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire ltg_pkg::ltg_cmd_t i_cmd,
    input wire logic [1:0] i_bank,
    input wire logic i_wr_last, // last write data beat on the bus
    input wire logic [1:0] i_pw_req, // wanted power state
    input wire logic i_derate,
    input wire logic i_configured,
    input wire logic i_slow_faw,
    output logic o_grant,
    output ltg_pkg::ltg_cmd_t o_cmd,
    output logic [1:0] o_bank,
    output logic o_cke,
    output logic [3:0] o_expire
);
    // cycles from ps: round up, with clock floor when period above 6 ns
    function automatic logic [15:0] cyc(input int ps, input int nck,
        input logic drt, input logic boot);
        int t, c;
        t = ps + (drt ? `LTG_DERATE_PS : 0);
        if (boot && t < `LTG_BOOT_PS)
            t = `LTG_BOOT_PS;
        c = (t + `LTG_CLK_PS - 1) / `LTG_CLK_PS;
        if (`LTG_CLK_PS > `LTG_FLOOR_PS && c < nck)
            c = nck;
        if (c < 1)
            c = 1;
        return 16'(c);
    endfunction

    logic boot;
    logic [15:0] rp_c, rc_c, ras_c, rrd_c, rtp_c, wtr_c, faw_c;
    logic [15:0] xp_c, xsr_c, esr_c;
    assign boot = !i_configured;
    assign rp_c = cyc(`LTG_RP_PS, `LTG_RP_NCK, i_derate, boot);
    assign ras_c = cyc(`LTG_RAS_PS, `LTG_RAS_NCK, i_derate, boot);
    // each term derated on its own
    assign rc_c = 16'(ras_c + rp_c);
    assign rrd_c = cyc(`LTG_RRD_PS, `LTG_RRD_NCK, i_derate, boot);
    assign rtp_c = cyc(`LTG_RTP_PS, `LTG_RTP_NCK, 1'b0, boot);
    assign wtr_c = cyc(`LTG_WTR_PS, `LTG_WTR_NCK, 1'b0, boot);
    assign faw_c = cyc(i_slow_faw ? `LTG_FAW_SLOW_PS : `LTG_FAW_PS,
        `LTG_FAW_NCK, 1'b0, boot);
    assign xp_c = cyc(`LTG_XP_PS, `LTG_XP_NCK, 1'b0, boot);
    assign xsr_c = cyc(`LTG_RFCAB_PS + `LTG_XSR_EXTRA_PS, `LTG_XSR_NCK,
        1'b0, boot);
    assign esr_c = cyc(`LTG_CKESR_PS, `LTG_CKESR_NCK, 1'b0, boot);

    ltg_bank_if bi ();
    ltg_bank u_bank (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .b(bi.bnk),
        .i_rtp_cyc(rtp_c),
        .i_pre_all(i_cmd == ltg_pkg::LTG_CMD_PREA)
    );

    ltg_pkg::ltg_pw_t pw_q, pw_d;
    logic [15:0] rrd_q, rrd_d, wtr_q, wtr_d, exit_q, exit_d;
    logic [23:0] low_q, low_d;
    logic [15:0] faw_q [4];
    logic [15:0] faw_d [4];
    logic [1:0] fp_q, fp_d;
    logic grant_q, grant_d, cke_q, cke_d;
    ltg_pkg::ltg_cmd_t cmd_q, cmd_d;
    logic [1:0] bank_q, bank_d;
    logic [3:0] exp_q;
    logic ok, fire, act_ok_all;

    // per-command legality
    always_comb begin
        act_ok_all = bi.act_ok[i_bank] && rrd_q == 16'h0
            && faw_q[fp_q] == 16'h0;
        unique case (i_cmd)
            ltg_pkg::LTG_CMD_ACT: ok = act_ok_all;
            // the last write beat of this very cycle blocks a read too
            ltg_pkg::LTG_CMD_RD: ok = wtr_q == 16'h0 && !i_wr_last;
            ltg_pkg::LTG_CMD_PRE: ok = bi.pre_ok[i_bank];
            ltg_pkg::LTG_CMD_PREA: ok = &bi.pre_ok;
            ltg_pkg::LTG_CMD_NOP: ok = 1'b1;
            default: ok = 1'b1;
        endcase
        fire = i_req && !grant_q && ok && pw_q == ltg_pkg::LTG_PW_ACTIVE
            && exit_q == 16'h0;
    end

    assign bi.act = fire && i_cmd == ltg_pkg::LTG_CMD_ACT;
    assign bi.pre = fire && (i_cmd == ltg_pkg::LTG_CMD_PRE
        || i_cmd == ltg_pkg::LTG_CMD_PREA);
    assign bi.rd = fire && i_cmd == ltg_pkg::LTG_CMD_RD;
    assign bi.wr_end = i_wr_last;
    assign bi.rp_cyc = rp_c;
    assign bi.rc_cyc = rc_c;
    assign bi.ras_cyc = ras_c;
    assign bi.rasmax_cyc = 24'(RASMAX_CYC);
    assign bi.bank = i_bank;

    // next values of shared timers, power state and outputs
    always_comb begin
        rrd_d = (rrd_q != 16'h0) ? rrd_q - 16'h1 : rrd_q;
        wtr_d = (wtr_q != 16'h0) ? wtr_q - 16'h1 : wtr_q;
        exit_d = (exit_q != 16'h0) ? exit_q - 16'h1 : exit_q;
        for (int i = 0; i < 4; i++)
            faw_d[i] = (faw_q[i] != 16'h0) ? faw_q[i] - 16'h1 : faw_q[i];
        fp_d = fp_q;
        low_d = (low_q != 24'hFFFFFF) ? low_q + 24'h1 : low_q;
        pw_d = pw_q;
        cke_d = cke_q;
        if (i_wr_last)
            wtr_d = wtr_c;
        if (bi.act) begin
            rrd_d = rrd_c;
            faw_d[fp_q] = faw_c;
            fp_d = fp_q + 2'h1;
        end
        unique case (pw_q)
            ltg_pkg::LTG_PW_ACTIVE: begin
                if (i_pw_req != 2'h0 && exit_q == 16'h0 && !i_req) begin
                    pw_d = ltg_pkg::ltg_pw_t'(i_pw_req);
                    cke_d = 1'b0;
                    low_d = 24'h0;
                end
            end
            ltg_pkg::LTG_PW_SREF: begin
                if (i_pw_req != 2'(ltg_pkg::LTG_PW_SREF)
                    && low_q >= 24'(esr_c)) begin
                    pw_d = ltg_pkg::LTG_PW_ACTIVE;
                    cke_d = 1'b1;
                    exit_d = xsr_c;
                end
            end
            ltg_pkg::LTG_PW_PDN: begin
                if (i_pw_req != 2'(ltg_pkg::LTG_PW_PDN)) begin
                    pw_d = ltg_pkg::LTG_PW_ACTIVE;
                    cke_d = 1'b1;
                    exit_d = xp_c;
                end
            end
            ltg_pkg::LTG_PW_DPD: begin
                if (i_pw_req != 2'(ltg_pkg::LTG_PW_DPD)
                    && low_q >= 24'(DPD_CYC)) begin
                    pw_d = ltg_pkg::LTG_PW_ACTIVE;
                    cke_d = 1'b1;
                    exit_d = xsr_c;
                end
            end
        endcase
        grant_d = fire;
        cmd_d = fire ? i_cmd : ltg_pkg::LTG_CMD_NOP;
        bank_d = fire ? i_bank : bank_q;
    end

    // registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rrd_q <= 16'h0;
            wtr_q <= 16'h0;
            exit_q <= 16'h0;
            for (int i = 0; i < 4; i++)
                faw_q[i] <= 16'h0;
            fp_q <= 2'h0;
            low_q <= 24'h0;
            pw_q <= ltg_pkg::LTG_PW_ACTIVE;
            cke_q <= 1'b1;
            grant_q <= 1'b0;
            cmd_q <= ltg_pkg::LTG_CMD_NOP;
            bank_q <= 2'h0;
            exp_q <= 4'h0;
        end else begin
            rrd_q <= rrd_d;
            wtr_q <= wtr_d;
            exit_q <= exit_d;
            faw_q <= faw_d;
            fp_q <= fp_d;
            low_q <= low_d;
            pw_q <= pw_d;
            cke_q <= cke_d;
            grant_q <= grant_d;
            cmd_q <= cmd_d;
            bank_q <= bank_d;
            exp_q <= bi.expire;
        end
    end

    assign o_grant = grant_q;
    assign o_cmd = cmd_q;
    assign o_bank = bank_q;
    assign o_cke = cke_q;
    assign o_expire = exp_q;

    // a granted activate must not follow another too closely
    property p_rrd;
        @(posedge i_clk) disable iff (i_rst)
        bi.act |=> !bi.act [*2];
    endproperty
    a_rrd: assert property (p_rrd)
        else $error("activates granted back to back");
    property p_cke_sref;
        @(posedge i_clk) disable iff (i_rst)
        $fell(o_cke) && pw_q == ltg_pkg::LTG_PW_SREF |=> !o_cke [*3];
    endproperty
    a_cke_sref: assert property (p_cke_sref)
        else $error("clock enable raised too soon in self-refresh");
    property p_exit;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_cke) |-> !o_grant ##1 !o_grant;
    endproperty
    a_exit: assert property (p_exit)
        else $error("command granted right after power exit");
    property p_rd_wtr;
        @(posedge i_clk) disable iff (i_rst)
        i_wr_last |-> !bi.rd [*3];
    endproperty
    a_rd_wtr: assert property (p_rd_wtr)
        else $error("read granted right after write data");
    sequence s_pre;
        bi.pre && i_cmd == ltg_pkg::LTG_CMD_PRE;
    endsequence
    property p_rp;
        @(posedge i_clk) disable iff (i_rst)
        s_pre |=> !(bi.act && i_bank == $past(i_bank))
            ##1 !(bi.act && i_bank == $past(i_bank, 2))
            ##1 !(bi.act && i_bank == $past(i_bank, 3));
    endproperty
    a_rp: assert property (p_rp)
        else $error("activate too soon after precharge");
    property p_prea;
        @(posedge i_clk) disable iff (i_rst)
        bi.pre && i_cmd == ltg_pkg::LTG_CMD_PREA |=> !bi.act [*3];
    endproperty
    a_prea: assert property (p_prea)
        else $error("activate too soon after all-bank precharge");
    property p_rtp;
        @(posedge i_clk) disable iff (i_rst)
        bi.rd |=> !(bi.pre && (i_bank == $past(i_bank)
            || i_cmd == ltg_pkg::LTG_CMD_PREA))
            ##1 !(bi.pre && (i_bank == $past(i_bank, 2)
            || i_cmd == ltg_pkg::LTG_CMD_PREA));
    endproperty
    a_rtp: assert property (p_rtp)
        else $error("precharge too soon after read");
    property p_xsr;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_cke) && $past(pw_q) == ltg_pkg::LTG_PW_SREF
            |-> !o_grant [*4];
    endproperty
    a_xsr: assert property (p_xsr)
        else $error("command too soon after self-refresh exit");
endmodule // ltg_guard

// >>> logic/ltg_pkg.sv
/*
 * types of the command spacing guard; no assumptions beyond the header.
 */
package ltg_pkg;
    typedef enum logic [2:0] {
        LTG_CMD_NOP = 3'h0,
        LTG_CMD_ACT = 3'h1,
        LTG_CMD_RD = 3'h2,
        LTG_CMD_WR = 3'h3,
        LTG_CMD_PRE = 3'h4,
        LTG_CMD_PREA = 3'h5,
        LTG_CMD_OTHER = 3'h6
    } ltg_cmd_t;
    typedef enum logic [1:0] {
        LTG_PW_ACTIVE = 2'h0,
        LTG_PW_SREF = 2'h1,
        LTG_PW_DPD = 2'h3,
        LTG_PW_PDN = 2'h2
    } ltg_pw_t;
endpackage
